// ==== hw/dtc_top.sv ====
// Dual timer control register block with two timer halves, output
// inversion, converter trigger gating and clock counting enable.
// Assumes an APB master on pclk and synchronous pin inputs.
//
// How it works
// - half B edge field picks rise, fall, both
// - half B stall bit lets half B freeze
// - half B enable starts its configured mode
// - reserved bit 7 always reads zero
// - half A invert bit flips pulse output
// - half A converter trigger gated by enable
// - clock counting advances only when enabled
// - half A edge field picks rise, fall, both
// - half A stall bit lets half A freeze
// - half A enable starts its configured mode
// - mode field selects one-shot, periodic, capture
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
module dtc_top #(
    parameter int HALF_WIDTH = 16,
    parameter int RTC_WIDTH  = 32
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 debug_halt,
    input  wire logic                 half_a_edge_in,
    input  wire logic                 half_b_edge_in,
    input  wire logic                 clock_tick_in,
    output logic                      half_a_pwm_out,
    output logic                      half_a_converter_trigger,
    output logic      [RTC_WIDTH-1:0] clock_count
);

    logic [11:0]           timer_control_q;
    logic [2:0]            timer_width_config_q;
    logic [1:0]            half_a_mode_select_q;
    logic [1:0]            half_b_mode_select_q;
    logic [RTC_WIDTH-1:0]  clock_count_q;
    logic                  pwm_q;
    logic                  trig_q;
    logic [31:0]           prdata_q;
    logic                  pslverr_q;
    logic                  pready_q;
    logic                  tick_prev_q;

    logic [HALF_WIDTH-1:0] a_count;
    logic [HALF_WIDTH-1:0] b_count;
    logic                  a_timeout;
    logic                  b_timeout;
    logic                  a_capture;
    logic                  b_capture;
    logic                  a_running;
    logic                  b_running;

    // APB decode; pready is registered, so each access phase has one wait state
    logic       acc;
    logic       wr_en;
    logic       rd_en;
    logic       hit_ctl;
    logic       hit_cfg;
    logic       hit_amr;
    logic       hit_bmr;
    logic       hit_sts;
    logic       mapped;
    logic [31:0] rd_mux;

    assign acc     = psel & penable & ~pready_q;
    assign hit_ctl = (paddr == dtc_pkg::TIMER_CONTROL_OFS);
    assign hit_cfg = (paddr == dtc_pkg::TIMER_WIDTH_CONFIG_OFS);
    assign hit_amr = (paddr == dtc_pkg::HALF_A_MODE_OFS);
    assign hit_bmr = (paddr == dtc_pkg::HALF_B_MODE_OFS);
    assign hit_sts = (paddr == dtc_pkg::HALF_STATUS_OFS);
    assign mapped  = hit_ctl | hit_cfg | hit_amr | hit_bmr | hit_sts;
    assign wr_en   = acc & pwrite & mapped;
    assign rd_en   = acc & ~pwrite;

    // Control bit slices
    logic       half_a_enable;
    logic       half_a_stall_enable;
    logic [1:0] half_a_edge_select;
    logic       clock_counting_enable;
    logic       half_a_converter_trigger_enable;
    logic       half_a_output_invert;
    logic       half_b_enable;
    logic       half_b_stall_enable;
    logic [1:0] half_b_edge_select;

    assign half_a_enable         =
        timer_control_q[dtc_pkg::HALF_A_ENABLE_BIT];
    assign half_a_stall_enable   =
        timer_control_q[dtc_pkg::HALF_A_STALL_BIT];
    assign half_a_edge_select    =
        timer_control_q[dtc_pkg::HALF_A_EDGE_LSB +: 2];
    assign clock_counting_enable =
        timer_control_q[dtc_pkg::CLOCK_COUNT_EN_BIT];
    assign half_a_converter_trigger_enable =
        timer_control_q[dtc_pkg::HALF_A_TRIG_EN_BIT];
    assign half_a_output_invert  =
        timer_control_q[dtc_pkg::HALF_A_INVERT_BIT];
    assign half_b_enable         =
        timer_control_q[dtc_pkg::HALF_B_ENABLE_BIT];
    assign half_b_stall_enable   =
        timer_control_q[dtc_pkg::HALF_B_STALL_BIT];
    assign half_b_edge_select    =
        timer_control_q[dtc_pkg::HALF_B_EDGE_LSB +: 2];

    // Read data mux; status word shows both halves' running bits and half A's count
    logic [31:0] ctl_rd;
    logic [31:0] sts_rd;

    assign ctl_rd = {20'h0_0000, timer_control_q};
    assign sts_rd = {14'h0000, b_running, a_running,
                     a_count[HALF_WIDTH-1 -: 16]};
    assign rd_mux = hit_ctl ? ctl_rd :
                    hit_cfg ? {29'h0000_0000, timer_width_config_q} :
                    hit_amr ? {30'h0000_0000, half_a_mode_select_q} :
                    hit_bmr ? {30'h0000_0000, half_b_mode_select_q} :
                    hit_sts ? sts_rd : 32'h0000_0000;

    // Bus handshake; unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= acc;
            pslverr_q <= acc & ~mapped;
        end
    end

    // Read data holds until the next read, so a late sampler still sees it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_q <= rd_mux;
        end
    end

    // Write strobes, one per stored register
    logic wr_ctl;
    logic wr_cfg;
    logic wr_amr;
    logic wr_bmr;

    assign wr_ctl = wr_en & hit_ctl;
    assign wr_cfg = wr_en & hit_cfg;
    assign wr_amr = wr_en & hit_amr;
    assign wr_bmr = wr_en & hit_bmr;

    // Bit 7 is masked at the write so it always reads back zero
    logic [11:0] ctl_keep;

    assign ctl_keep = ~(12'h001 << dtc_pkg::RESERVED_BIT);

    // Control word; bits above 11 are never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_q <= dtc_pkg::TIMER_CONTROL_RST;
        end else if (wr_ctl) begin
            timer_control_q <= pwdata[11:0] & ctl_keep;
        end
    end

    // Width config is stored only; the halves keep their fixed width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_width_config_q <= dtc_pkg::WIDTH_CONFIG_RST;
        end else if (wr_cfg) begin
            timer_width_config_q <= pwdata[2:0];
        end
    end

    // Mode fields apply at once, even to a running half
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_a_mode_select_q <= dtc_pkg::MODE_RST;
        end else if (wr_amr) begin
            half_a_mode_select_q <= pwdata[1:0];
        end
    end

    // Half B mode field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_b_mode_select_q <= dtc_pkg::MODE_RST;
        end else if (wr_bmr) begin
            half_b_mode_select_q <= pwdata[1:0];
        end
    end

    // Per-half controls and results; index 0 is half A, 1 is half B
    logic [1:0]            half_en;
    logic [1:0]            half_stall;
    logic [1:0][1:0]       half_mode;
    logic [1:0][1:0]       half_edge;
    logic [1:0]            half_pin;
    logic [HALF_WIDTH-1:0] half_count   [2];
    logic                  half_timeout [2];
    logic                  half_capture [2];
    logic                  half_running [2];

    // Enable starts the mode chosen in that half's mode field
    assign half_en    = {half_b_enable, half_a_enable};
    assign half_stall = {half_b_stall_enable, half_a_stall_enable};
    assign half_mode  = {half_b_mode_select_q, half_a_mode_select_q};
    assign half_edge  = {half_b_edge_select, half_a_edge_select};
    assign half_pin   = {half_b_edge_in, half_a_edge_in};

    // Both halves share one timer body
    for (genvar h = 0; h < 2; h++) begin : g_half
        dtc_half #(
            .WIDTH      (HALF_WIDTH)
        ) u_half (
            .pclk       (pclk),
            .presetn    (presetn),
            .enable     (half_en[h]),
            .stall_en   (half_stall[h]),
            .debug_halt (debug_halt),
            .mode       (half_mode[h]),
            .edge_sel   (half_edge[h]),
            .edge_in    (half_pin[h]),
            .load_value ({HALF_WIDTH{1'b1}}),
            .count_q    (half_count[h]),
            .timeout_q  (half_timeout[h]),
            .capture_q  (half_capture[h]),
            .running_q  (half_running[h])
        );
    end

    // Half A drives the pins; half B reaches the status word only
    assign a_count   = half_count[0];
    assign a_timeout = half_timeout[0];
    assign a_capture = half_capture[0];
    assign a_running = half_running[0];
    assign b_count   = half_count[1];
    assign b_timeout = half_timeout[1];
    assign b_capture = half_capture[1];
    assign b_running = half_running[1];

    // Raw pulse: high in the upper half of the count range while half A runs
    logic raw_pwm;
    logic raw_trig;

    assign raw_pwm  = a_running & a_count[HALF_WIDTH-1];
    // Converter side must still enable itself and select this source
    assign raw_trig = a_timeout | a_capture;

    // Inversion also applies while the half is idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_q <= 1'b0;
        end else begin
            pwm_q <= raw_pwm ^ half_a_output_invert;
        end
    end

    // An event while the trigger is disabled is lost, not deferred
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= raw_trig & half_a_converter_trigger_enable;
        end
    end

    // Clock counting on rising edges of the tick input
    logic tick_rise;

    assign tick_rise = clock_tick_in & ~tick_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_prev_q <= 1'b0;
        end else begin
            tick_prev_q <= clock_tick_in;
        end
    end

    // A tick while disabled is dropped, not remembered for later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_count_q <= '0;
        end else if (clock_counting_enable && tick_rise) begin
            clock_count_q <= clock_count_q + 1'b1;
        end
    end

    // Half B timeout, capture and count have no output here; only its running bit reaches status
    logic unused_b;

    assign unused_b = b_timeout ^ b_capture ^ (^b_count);

    assign prdata                   = prdata_q;
    assign pready                   = pready_q;
    assign pslverr                  = pslverr_q;
    assign half_a_pwm_out           = pwm_q;
    assign half_a_converter_trigger = trig_q;
    assign clock_count              = clock_count_q;

endmodule

// ==== hw/dtc_pkg.sv ====
// Package for the dual timer control block: register map, control
// field positions, mode and edge encodings, reset values.
// Assumes a 32-bit APB register bus on a single clock.
package dtc_pkg;

    // Register byte offsets
    localparam logic [7:0] TIMER_CONTROL_OFS      = 8'h0c;
    localparam logic [7:0] TIMER_WIDTH_CONFIG_OFS = 8'h00;
    localparam logic [7:0] HALF_A_MODE_OFS        = 8'h04;
    localparam logic [7:0] HALF_B_MODE_OFS        = 8'h08;
    localparam logic [7:0] HALF_STATUS_OFS        = 8'h10;

    // Control field positions
    localparam int HALF_A_ENABLE_BIT   = 0;
    localparam int HALF_A_STALL_BIT    = 1;
    localparam int HALF_A_EDGE_LSB     = 2;
    localparam int CLOCK_COUNT_EN_BIT  = 4;
    localparam int HALF_A_TRIG_EN_BIT  = 5;
    localparam int HALF_A_INVERT_BIT   = 6;
    localparam int RESERVED_BIT        = 7;
    localparam int HALF_B_ENABLE_BIT   = 8;
    localparam int HALF_B_STALL_BIT    = 9;
    localparam int HALF_B_EDGE_LSB     = 10;
    localparam int CONTROL_WIDTH       = 12;

    // Reset values
    localparam logic [11:0] TIMER_CONTROL_RST = 12'h000;
    localparam logic [1:0]  MODE_RST          = 2'h0;
    localparam logic [2:0]  WIDTH_CONFIG_RST  = 3'h0;

    // Half mode encodings
    localparam logic [1:0] MODE_RESERVED = 2'h0;
    localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;
    localparam logic [1:0] MODE_CAPTURE  = 2'h3;

    // Edge encodings
    localparam logic [1:0] EDGE_RISING   = 2'h0;
    localparam logic [1:0] EDGE_FALLING  = 2'h1;
    localparam logic [1:0] EDGE_RESERVED = 2'h2;
    localparam logic [1:0] EDGE_BOTH     = 2'h3;

    typedef enum logic [1:0] {
        DTC_IDLE,
        DTC_RUN,
        DTC_DONE
    } dtc_state_t;

endpackage

// ==== hw/dtc_half.sv ====
// One timer half: counts down in one-shot or periodic mode, or counts
// selected input edges in capture mode; honours stall and enable.
// Assumes edge input already synchronous to pclk.
`timescale 1ns/1ps
module dtc_half #(
    parameter int WIDTH = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             enable,
    input  wire logic             stall_en,
    input  wire logic             debug_halt,
    input  wire logic [1:0]       mode,
    input  wire logic [1:0]       edge_sel,
    input  wire logic             edge_in,
    input  wire logic [WIDTH-1:0] load_value,
    output logic      [WIDTH-1:0] count_q,
    output logic                  timeout_q,
    output logic                  capture_q,
    output logic                  running_q
);

    dtc_pkg::dtc_state_t state_q;
    dtc_pkg::dtc_state_t state_d;
    logic                edge_prev_q;
    logic                rise;
    logic                fall;
    logic                edge_hit;
    logic                held;
    logic                at_zero;
    logic                capture_mode;

    // Edge detect on the registered copy, reserved edge code counts none
    assign rise         = edge_in & ~edge_prev_q;
    assign fall         = ~edge_in & edge_prev_q;
    assign edge_hit     = (edge_sel == dtc_pkg::EDGE_RISING)  ? rise :
                          (edge_sel == dtc_pkg::EDGE_FALLING) ? fall :
                          (edge_sel == dtc_pkg::EDGE_BOTH)    ?
                          (rise | fall) : 1'b0;
    // Stall only freezes the half when software allowed it
    assign held         = stall_en & debug_halt;
    assign at_zero      = (count_q == '0);
    assign capture_mode = (mode == dtc_pkg::MODE_CAPTURE);

    // Next state; reserved mode keeps the half idle even if enabled
    always_comb begin
        state_d = state_q;
        case (state_q)
            dtc_pkg::DTC_IDLE: begin
                if (enable && mode != dtc_pkg::MODE_RESERVED) begin
                    state_d = dtc_pkg::DTC_RUN;
                end
            end
            dtc_pkg::DTC_RUN: begin
                if (!enable) begin
                    state_d = dtc_pkg::DTC_IDLE;
                end else if (!held && !capture_mode && at_zero &&
                             mode == dtc_pkg::MODE_ONE_SHOT) begin
                    state_d = dtc_pkg::DTC_DONE;
                end
            end
            dtc_pkg::DTC_DONE: begin
                if (!enable) begin
                    state_d = dtc_pkg::DTC_IDLE;
                end
            end
            default: state_d = dtc_pkg::DTC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= dtc_pkg::DTC_IDLE;
            edge_prev_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            edge_prev_q <= edge_in;
        end
    end

    // Counter: loads on start, decrements or counts edges while running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q   <= '0;
            timeout_q <= 1'b0;
            capture_q <= 1'b0;
            running_q <= 1'b0;
        end else begin
            timeout_q <= 1'b0;
            capture_q <= 1'b0;
            running_q <= (state_d == dtc_pkg::DTC_RUN);
            if (state_q == dtc_pkg::DTC_IDLE) begin
                count_q <= load_value;
            end else if (state_q == dtc_pkg::DTC_RUN && !held) begin
                if (capture_mode) begin
                    if (edge_hit) begin
                        count_q   <= count_q - 1'b1;
                        capture_q <= 1'b1;
                    end
                end else if (at_zero) begin
                    count_q   <= load_value;
                    timeout_q <= 1'b1;
                end else begin
                    count_q <= count_q - 1'b1;
                end
            end
        end
    end

endmodule

// ==== sim/dtc_monitor.sv ====
// Checker for dtc_top: APB answer timing and control-bit effects.
// Sees only top ports; a shadow of the control word tracks writes.
`timescale 1ns/1ps
module dtc_monitor #(
    parameter int RTC_WIDTH = 32
) (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 debug_halt,
    input wire logic                 half_a_edge_in,
    input wire logic                 half_b_edge_in,
    input wire logic                 clock_tick_in,
    input wire logic                 half_a_pwm_out,
    input wire logic                 half_a_converter_trigger,
    input wire logic [RTC_WIDTH-1:0] clock_count
);
    logic [11:0] ctl_q, ctl_d;
    logic [1:0]  age_q, age_d;
    wire         acc = psel && penable && !pready;
    wire         is_ctl = paddr == dtc_pkg::TIMER_CONTROL_OFS;
    wire         mapped = is_ctl || paddr == 8'h00 || paddr == 8'h04 ||
                          paddr == 8'h08 || paddr == 8'h10;
    wire         ctl_wr = pready && pwrite && is_ctl;
    // Age saturates at 3 so settled behaviour is judged only after writes
    assign ctl_d = ctl_wr ? pwdata[11:0] : ctl_q;
    assign age_d = ctl_wr ? 2'h0 : ((age_q == 2'h3) ? age_q : age_q + 2'h1);

    // Shadow control word, cleared with the device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 12'h000;
            age_q <= 2'h0;
        end else begin
            ctl_q <= ctl_d;
            age_q <= age_d;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_unmapped;
        acc && !mapped;
    endsequence
    sequence s_ctl_read;
        pready && !pwrite && is_ctl;
    endsequence

    property p_ready_pulse; pready |=> !pready; endproperty
    property p_ready_answer; acc |=> pready; endproperty
    property p_ready_cause; pready |-> $past(acc); endproperty
    property p_err_unmapped; s_unmapped |=> pready && pslverr; endproperty
    property p_reserved_zero;
        s_ctl_read |-> prdata[31:12] == 20'h0_0000 && !prdata[7];
    endproperty
    property p_reset_zero;
        $rose(presetn) |-> clock_count == '0 && !half_a_pwm_out &&
            !half_a_converter_trigger;
    endproperty
    property p_count_step;
        !$stable(clock_count) |-> clock_count == $past(clock_count) + 1'b1;
    endproperty
    property p_count_hold;
        age_q == 2'h3 && !ctl_q[4] |=> $stable(clock_count);
    endproperty
    property p_trig_gate;
        half_a_converter_trigger |-> ctl_q[5] || $past(ctl_q[5]);
    endproperty
    property p_pwm_idle;
        age_q == 2'h3 && !ctl_q[0] |-> half_a_pwm_out == ctl_q[6];
    endproperty
    property p_a_off;
        age_q == 2'h3 && !ctl_q[0] |-> !half_a_converter_trigger;
    endproperty

    a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
    a_ready_answer: assert property (p_ready_answer) else $error("no pready");
    a_ready_cause: assert property (p_ready_cause) else $error("stray pready");
    a_err_unmapped: assert property (p_err_unmapped) else $error("no pslverr");
    a_reserved_zero:
        assert property (p_reserved_zero) else $error("reserved bits set");
    a_reset_zero: assert property (p_reset_zero) else $error("reset");
    a_count_step: assert property (p_count_step) else $error("jump");
    a_count_hold: assert property (p_count_hold) else $error("moved");
    a_trig_gate: assert property (p_trig_gate) else $error("trigger");
    a_pwm_idle: assert property (p_pwm_idle) else $error("pwm level");
    a_a_off: assert property (p_a_off) else $error("half A active");
endmodule

bind dtc_top dtc_monitor #(.RTC_WIDTH(RTC_WIDTH)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt),
    .half_a_edge_in(half_a_edge_in), .half_b_edge_in(half_b_edge_in),
    .clock_tick_in(clock_tick_in), .half_a_pwm_out(half_a_pwm_out),
    .half_a_converter_trigger(half_a_converter_trigger),
    .clock_count(clock_count)
);

// ==== sim/dtc_top_bench.sv ====
// Self-checking bench for dtc_top: APB master tasks, random control
// words, edge and tick pulses. Expects dtc_monitor bound to the DUT.
`timescale 1ns/1ps
module dtc_top_bench;
    localparam logic [7:0] CTL = dtc_pkg::TIMER_CONTROL_OFS;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        debug_halt, ea, eb, tick, pwm, trig;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, st, d, dlt, cnt;
    logic [1:0]  edg [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int          error_cnt, n_compared, trig_cnt, seed, k;

    dtc_top i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt),
        .half_a_edge_in(ea), .half_b_edge_in(eb), .clock_tick_in(tick),
        .half_a_pwm_out(pwm), .half_a_converter_trigger(trig),
        .clock_count(cnt)
    );

    always #25 pclk = ~pclk;

    // Trigger is a one-cycle pulse, so each sampled high is one event
    always @(posedge pclk) begin
        if (trig === 1'b1) trig_cnt++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; waits for pready without assuming a latency
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) error_cnt++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, rd, err);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, rd, err);
        chk(rd, e);
        chk({31'h0, err}, 32'h0000_0000);
    endtask

    // Pins held three cycles per level so the edge detectors see each edge
    task automatic pulse(input int sel, input int n);
        repeat (n) begin
            for (int v = 1; v >= 0; v--) begin
                if (sel == 0) ea <= v[0];
                else tick <= v[0];
                repeat (3) @(posedge pclk);
            end
        end
    endtask

    task automatic edge_delta(output logic [31:0] o, input int n);
        logic [31:0] c0;
        apb(1'b0, 8'h10, 32'h0000_0000, c0, err);
        pulse(0, n);
        apb(1'b0, 8'h10, 32'h0000_0000, st, err);
        o = {16'h0000, c0[15:0] - st[15:0]};
    endtask

    function automatic logic [31:0] ctl_exp(input logic [31:0] v);
        return {20'h0_0000, v[11:8], 1'b0, v[6:0]};
    endfunction

    function automatic logic [31:0] dec_exp(input logic [1:0] e);
        return (e == 2'h3) ? 32'h4 : (e == 2'h2) ? 32'h0 : 32'h2;
    endfunction

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        conclude();
    end

    initial begin
        seed = 32'h0000_3064;
        {presetn, psel, penable, pwrite, debug_halt, ea, eb, tick} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(CTL, 32'h0000_0000);
        chk(cnt, 32'h0000_0000);
        $display("test reset done");
        // Corners first, then random words; mode 0 keeps half A idle
        for (int i = 0; i < 14; i++) begin
            d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0080 :
                $random(seed);
            wreg(CTL, d);
            rchk(CTL, ctl_exp(d));
            chk({31'h0, pwm}, {31'h0, d[6]});
        end
        wreg(CTL, 32'h0000_0041);
        wreg(8'h14, 32'hffff_ffff);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b0, 8'h14, 32'h0000_0000, rd, err);
        chk({err, rd[30:0]}, 32'h8000_0000);
        rchk(CTL, 32'h0000_0041);
        $display("test control register done");
        k = 1 + ($unsigned($random(seed)) % 8);
        wreg(CTL, 32'h0000_0010);
        pulse(1, k);
        chk(cnt, k);
        wreg(CTL, 32'h0000_0000);
        pulse(1, 3);
        chk(cnt, k);
        $display("test clock counting done");
        // Reserved mode keeps half A idle; timed modes count down
        for (int m = 0; m < 3; m++) begin
            wreg(8'h04, m);
            wreg(CTL, 32'h0000_0001);
            apb(1'b0, 8'h10, 32'h0000_0000, rd, err);
            apb(1'b0, 8'h10, 32'h0000_0000, st, err);
            chk({31'h0, st[16]}, {31'h0, m != 0});
            chk({31'h0, rd[15:0] != st[15:0]}, {31'h0, m != 0});
        end
        $display("test mode select done");
        wreg(8'h04, 32'h0000_0003);
        for (int i = 0; i < 8; i++) begin
            wreg(CTL, {26'h0, i[2], 1'b0, edg[i % 4], 2'h1});
            trig_cnt = 0;
            edge_delta(dlt, 2);
            chk(dlt, dec_exp(edg[i % 4]));
            chk({31'h0, st[16]}, 32'h0000_0001);
            chk(trig_cnt, i[2] ? dec_exp(edg[i % 4]) : 32'h0);
        end
        $display("test capture done");
        for (int j = 0; j < 3; j++) begin
            wreg(CTL, (j == 1) ? 32'h0000_0001 : 32'h0000_0003);
            debug_halt <= (j != 2);
            edge_delta(dlt, 1);
            chk(dlt, (j == 0) ? 32'h0000_0000 : 32'h0000_0001);
        end
        debug_halt <= 1'b0;
        $display("test stall done");
        wreg(8'h08, 32'h0000_0002);
        wreg(CTL, 32'h0000_0100);
        rchk(8'h10, 32'h0002_ffff);
        wreg(CTL, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000, st, err);
        chk({30'h0, st[17:16]}, 32'h0000_0000);
        $display("test half B done");
        wreg(CTL, 32'h0000_0f7f);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(CTL, 32'h0000_0000);
        chk(cnt, 32'h0000_0000);
        $display("test second reset done");
        conclude();
    end
endmodule
